/* File: core/swr_pkg.sv */
// constants for the supervisor watchdog reset block
package swr_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CE_HOLD_NS      = 12_000;
  // longest time: round down
  localparam int unsigned CE_HOLD_CYC     = CE_HOLD_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned CNT_W           = 24;
  localparam logic [CNT_W-1:0] CE_HOLD_CNT = CNT_W'(CE_HOLD_CYC);
  // internal oscillator tick period in clock cycles
  localparam logic [CNT_W-1:0] INT_OSC_DIV = 24'h000019;
  // 200ms reset hold at the 1 MHz internal tick
  localparam logic [CNT_W-1:0] RST_TICKS_DEF  = 24'h030D40;
  localparam logic [CNT_W-1:0] WD_FAST_DEF    = 24'h0186A0;
  localparam logic [CNT_W-1:0] WD_SLOW_DEF    = 24'h186A00;
  localparam logic [CNT_W-1:0] CNT_ZERO       = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE        = 24'h000001;
  // three-level kick input code
  localparam logic [1:0] KICK_LOW  = 2'h0;
  localparam logic [1:0] KICK_HIGH = 2'h1;
  localparam logic [1:0] KICK_MID  = 2'h2;
  typedef enum logic [1:0] {
    SWR_RST_HOLD = 2'b00,
    SWR_RUN      = 2'b01,
    SWR_WD_RST   = 2'b10
  } swr_state_t;
endpackage

/* File: core/swr_top.sv */
// supervisor: reset generator, watchdog, chip-enable gate, supply switch
// Operation
// RQ1 - backed rail uses main supply when above backup and above threshold
// RQ2 - backed rail uses backup when main below backup and below threshold
// RQ3 - backup-active output high on backup rail, low on main rail
// RQ4 - low-line output follows main-below-threshold with no delay
// RQ5 - select high: internal ticks time periods, timing input picks watchdog speed
// RQ6 - select low: periods timed from ticks of external timing input
// RQ7 - power-fail output low while sense is below its comparison level
// RQ8 - power-fail result touches nothing else in the block
// RQ9 - kick stuck longer than timeout: fault low and reset pulse
// RQ10 - fault output stays low until next kick transition
// RQ11 - kick is three-level; mid level disables watchdog; host toggles kick
// RQ12 - fault output held high while reset asserted
// RQ13 - in normal operation chip-enable passes straight through
// RQ14 - during reset pass path blocked; low only with input low and supply good; code does not check supply during the RQ15 hold
// RQ15 - enable low at reset entry stays low 12us or until input rises
// RQ16 - reset while supply low; held 200ms after supply recovers
// RQ17 - active-high reset is complement of active-low reset
// RQ18 - watchdog count restarts on each kick edge, cleared during reset
// RQ19 - periods are tick counters with parameter terminal counts
`timescale 1ns/100ps
module swr_top #(
  parameter logic [swr_pkg::CNT_W-1:0] RST_TICKS = swr_pkg::RST_TICKS_DEF,
  parameter logic [swr_pkg::CNT_W-1:0] WD_FAST   = swr_pkg::WD_FAST_DEF,
  parameter logic [swr_pkg::CNT_W-1:0] WD_SLOW   = swr_pkg::WD_SLOW_DEF
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // comparator results from the analog front end
  input  wire logic       main_above_thresh,
  input  wire logic       main_above_backup,
  input  wire logic       power_fail_sense_in,
  // timing and kick
  input  wire logic       timing_source_select,
  input  wire logic       timing_source_in,
  input  wire logic [1:0] watchdog_kick_in,
  // chip enable
  input  wire logic       chip_enable_in_n,
  // outputs
  output logic            rail_on_main,
  output logic            backup_active_out,
  output logic            low_line_out_n,
  output logic            power_fail_out_n,
  output logic            watchdog_fault_out_n,
  output logic            chip_enable_out_n,
  output logic            reset_out_n,
  output logic            reset_out
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0]                 s_thr, s_bak, s_pf, s_sel, s_osc, s_ce;
    logic [2:0]                 s_k0, s_k1;
    logic                       thr, bak, pf, sel, osc, ce;
    logic [1:0]                 kick;
    swr_pkg::swr_state_t        st;
    logic [swr_pkg::CNT_W-1:0]  div;
    logic [swr_pkg::CNT_W-1:0]  tcnt;
    logic [swr_pkg::CNT_W-1:0]  wcnt;
    logic [swr_pkg::CNT_W-1:0]  ccnt;
    logic                       ce_hold;
    logic                       on_main, lowl_n, pf_n, wdo_n, ceo_n, rst_o_n;
    // registered copies so that every pin leaves a flop with no gate after it
    logic                       bat_on, wdo_o_n, rst_o;
  } swr_regs_t;

  swr_regs_t r;
  swr_regs_t next_r;

  // three-stage sync, change accepted when stages two and three agree
  function automatic logic sync_take(input logic [2:0] s, input logic cur);
    sync_take = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic                      tick;
  logic                      osc_edge;
  logic                      kick_edge;
  logic                      in_reset;
  logic [swr_pkg::CNT_W-1:0] wd_limit;

  always_comb
  begin
    next_r = r;
    next_r.s_thr = {r.s_thr[1:0], main_above_thresh};
    next_r.s_bak = {r.s_bak[1:0], main_above_backup};
    next_r.s_pf  = {r.s_pf[1:0], power_fail_sense_in};
    next_r.s_sel = {r.s_sel[1:0], timing_source_select};
    next_r.s_osc = {r.s_osc[1:0], timing_source_in};
    next_r.s_ce  = {r.s_ce[1:0], chip_enable_in_n};
    next_r.s_k0  = {r.s_k0[1:0], watchdog_kick_in[0]};
    next_r.s_k1  = {r.s_k1[1:0], watchdog_kick_in[1]};
    next_r.thr = sync_take(r.s_thr, r.thr);
    next_r.bak = sync_take(r.s_bak, r.bak);
    next_r.pf  = sync_take(r.s_pf, r.pf);
    next_r.sel = sync_take(r.s_sel, r.sel);
    next_r.osc = sync_take(r.s_osc, r.osc);
    next_r.ce  = sync_take(r.s_ce, r.ce);
    next_r.kick = {sync_take(r.s_k1, r.kick[1]), sync_take(r.s_k0, r.kick[0])};

    // tick source: internal divider or rising edges of external input
    osc_edge = next_r.osc & ~r.osc;
    next_r.div = (r.div >= swr_pkg::INT_OSC_DIV - swr_pkg::CNT_ONE) ? swr_pkg::CNT_ZERO
                 : r.div + swr_pkg::CNT_ONE;
    tick = r.sel ? (r.div == swr_pkg::CNT_ZERO) : osc_edge; // RQ5 RQ6
    // in internal mode the timing input picks fast (low) or slow (high)
    wd_limit = (r.sel && r.osc) ? WD_SLOW : WD_FAST; // RQ5 RQ19

    // every change of the decoded level counts as a kick
    kick_edge = (next_r.kick != r.kick);
    in_reset = (r.st != swr_pkg::SWR_RUN);

    case (r.st)
      swr_pkg::SWR_RST_HOLD, swr_pkg::SWR_WD_RST:
      begin
        next_r.wcnt = swr_pkg::CNT_ZERO; // RQ18
        if (!r.thr)
        begin
          next_r.st = swr_pkg::SWR_RST_HOLD;
          next_r.tcnt = swr_pkg::CNT_ZERO;
        end
        else if (tick)
        begin
          if (r.tcnt >= RST_TICKS - swr_pkg::CNT_ONE) // RQ16 RQ19
          begin
            next_r.st = swr_pkg::SWR_RUN;
            next_r.tcnt = swr_pkg::CNT_ZERO;
          end
          else
            next_r.tcnt = r.tcnt + swr_pkg::CNT_ONE;
        end
      end
      swr_pkg::SWR_RUN:
      begin
        next_r.tcnt = swr_pkg::CNT_ZERO;
        if (!r.thr)
        begin
          next_r.st = swr_pkg::SWR_RST_HOLD; // RQ16
          next_r.wcnt = swr_pkg::CNT_ZERO; // RQ18
        end
        else if (kick_edge || r.kick == swr_pkg::KICK_MID)
          next_r.wcnt = swr_pkg::CNT_ZERO; // RQ18 RQ11
        else if (tick)
        begin
          if (r.wcnt >= wd_limit - swr_pkg::CNT_ONE) // RQ9
          begin
            next_r.st = swr_pkg::SWR_WD_RST;
            next_r.wdo_n = 1'b0;
            next_r.wcnt = swr_pkg::CNT_ZERO;
          end
          else
            next_r.wcnt = r.wcnt + swr_pkg::CNT_ONE;
        end
      end
      default:
        next_r.st = swr_pkg::SWR_RST_HOLD;
    endcase

    // stored fault bit outlives the reset pulse and is masked on the way
    // out, so the low shows once reset ends and stays until the kick moves
    if (kick_edge)
      next_r.wdo_n = 1'b1; // RQ10
    next_r.rst_o_n = (next_r.st == swr_pkg::SWR_RUN);
    next_r.rst_o = (next_r.st != swr_pkg::SWR_RUN); // RQ17
    next_r.wdo_o_n = next_r.wdo_n | ~next_r.rst_o_n; // RQ12
    next_r.on_main = r.thr & r.bak ? 1'b1 : ((!r.thr && !r.bak) ? 1'b0 : r.on_main); // RQ1 RQ2
    next_r.bat_on = ~next_r.on_main; // RQ3
    next_r.lowl_n = r.thr; // RQ4
    next_r.pf_n = r.pf; // RQ7 RQ8

    // chip enable gate
    if (!in_reset && next_r.st == swr_pkg::SWR_RUN)
    begin
      next_r.ceo_n = r.ce; // RQ13
      next_r.ce_hold = 1'b0;
      next_r.ccnt = swr_pkg::CNT_ZERO;
    end
    else if (!in_reset)
    begin
      // reset entering: keep an active access going a short while
      next_r.ce_hold = ~r.ce; // RQ15
      next_r.ceo_n = r.ce;
      next_r.ccnt = swr_pkg::CNT_ZERO;
    end
    else if (r.ce_hold && !r.ce && r.ccnt < swr_pkg::CE_HOLD_CNT - swr_pkg::CNT_ONE)
    begin
      next_r.ccnt = r.ccnt + swr_pkg::CNT_ONE; // RQ15
      next_r.ceo_n = 1'b0;
    end
    else
    begin
      next_r.ce_hold = 1'b0;
      next_r.ceo_n = 1'b1; // RQ14
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.wdo_n <= 1'b1;
      r.ceo_n <= 1'b1;
      r.s_ce <= 3'h7;
      r.ce <= 1'b1;
      r.kick <= swr_pkg::KICK_MID;
      r.s_k1 <= 3'h7;
      r.sel <= 1'b1;
      r.s_sel <= 3'h7;
      r.on_main <= 1'b1;
      r.pf_n <= 1'b1;
      r.pf <= 1'b1;
      r.s_pf <= 3'h7;
      r.wdo_o_n <= 1'b1;
      r.rst_o <= 1'b1;
    end
    else
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // every pin is a plain flop output
  assign rail_on_main         = r.on_main;
  assign backup_active_out    = r.bat_on; // RQ3
  assign low_line_out_n       = r.lowl_n;
  assign power_fail_out_n     = r.pf_n;
  assign watchdog_fault_out_n = r.wdo_o_n; // RQ12
  assign chip_enable_out_n    = r.ceo_n;
  assign reset_out_n          = r.rst_o_n;
  assign reset_out            = r.rst_o; // RQ17

  ////////////////////////////////////////////////////////////////////////////
  a_reset_complement: assert property (@(posedge clock) disable iff (!rst_n) // RQ17
    reset_out == !reset_out_n) else $error("reset outputs not complementary");
  a_lowline_follow: assert property (@(posedge clock) disable iff (!rst_n) // RQ4
    low_line_out_n == $past(r.thr)) else $error("low line lags supply");
  a_supply_low_rst: assert property (@(posedge clock) disable iff (!rst_n) // RQ16
    !r.thr |=> !reset_out_n) else $error("no reset with supply low");
  a_wdo_high_rst: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
    !reset_out_n |-> watchdog_fault_out_n) else $error("fault low during reset");
  a_mid_no_fault: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
    (r.st == swr_pkg::SWR_RUN && r.kick == swr_pkg::KICK_MID) |=> r.wcnt == '0)
    else $error("watchdog runs with kick floating");
  a_kick_clears: assert property (@(posedge clock) disable iff (!rst_n) // RQ10
    kick_edge |=> r.wdo_n) else $error("fault not cleared by kick");
  a_ce_blocked: assert property (@(posedge clock) disable iff (!rst_n) // RQ14
    (in_reset && !r.ce_hold) |=> chip_enable_out_n) else $error("enable leaks in reset");
  a_ce_pass: assert property (@(posedge clock) disable iff (!rst_n) // RQ13
    (r.st == swr_pkg::SWR_RUN && $past(r.st) == swr_pkg::SWR_RUN) |=>
      (chip_enable_out_n == $past(r.ce) || r.st != swr_pkg::SWR_RUN))
    else $error("enable not passed");
  a_batt_flag: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
    (r.thr && r.bak) |=> !backup_active_out) else $error("backup flag on main");
  a_pf_follow: assert property (@(posedge clock) disable iff (!rst_n) // RQ7
    power_fail_out_n == $past(r.pf)) else $error("power fail mismatch");

  ////////////////////////////////////////////////////////////////////////////
  // supply switch and flags follow the synced comparators
  a_rail_main: assert property (@(posedge clock) disable iff (!rst_n) // RQ1
    (r.thr && r.bak) |=> rail_on_main)
    else $error("rail not on main supply");
  a_rail_backup: assert property (@(posedge clock) disable iff (!rst_n) // RQ2
    (!r.thr && !r.bak) |=> !rail_on_main)
    else $error("rail not on backup supply");
  a_batt_inverse: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
    backup_active_out == !rail_on_main)
    else $error("backup flag disagrees with rail");

  // timing source: with select low only timing input edges tick
  a_tick_ext: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
    !r.sel |-> (tick == osc_edge))
    else $error("tick not from timing input");
  a_div_range: assert property (@(posedge clock) disable iff (!rst_n) // RQ19
    r.div < swr_pkg::INT_OSC_DIV)
    else $error("internal divider out of range");

  // watchdog and reset counters
  a_wd_timeout: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
    (r.st == swr_pkg::SWR_RUN && r.thr && tick && !kick_edge && r.kick != swr_pkg::KICK_MID
      && r.wcnt >= wd_limit - swr_pkg::CNT_ONE) |=> (!reset_out_n && !r.wdo_n))
    else $error("stuck kick gave no watchdog reset");
  a_wcnt_reset: assert property (@(posedge clock) disable iff (!rst_n) // RQ18
    (r.st != swr_pkg::SWR_RUN) |=> (r.wcnt == swr_pkg::CNT_ZERO))
    else $error("watchdog count runs in reset");
  a_tcnt_range: assert property (@(posedge clock) disable iff (!rst_n) // RQ19
    r.tcnt < RST_TICKS)
    else $error("reset hold count out of range");
  a_fault_hold: assert property (@(posedge clock) disable iff (!rst_n) // RQ10
    (!r.wdo_n && !kick_edge) |=> !r.wdo_n)
    else $error("fault cleared without a kick");
  a_mid_run: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
    (r.kick == swr_pkg::KICK_MID && r.st == swr_pkg::SWR_RUN && r.thr) |=> reset_out_n)
    else $error("reset with kick floating");

  // chip enable gate during reset
  a_ce_hold_len: assert property (@(posedge clock) disable iff (!rst_n) // RQ15
    r.ccnt < swr_pkg::CE_HOLD_CNT)
    else $error("enable hold runs too long");
  a_ce_rise_cut: assert property (@(posedge clock) disable iff (!rst_n) // RQ15
    (in_reset && r.ce) |=> chip_enable_out_n)
    else $error("enable stays low after input rose");
endmodule

/* File: bench/swr_host_model.sv */
// host model that drives the three-level watchdog kick
`timescale 1ns/100ps
module swr_host_model (
  // clock
  input  wire logic        clock,
  // 0 toggle, 1 hold, 2 float
  input  wire logic [1:0]  kick_mode,
  input  wire logic [15:0] period,
  // kick line
  output logic [1:0]       watchdog_kick_in
);
  int cnt = 0;
  initial watchdog_kick_in = swr_pkg::KICK_MID;
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clock)
  begin
    cnt = cnt + 1;
    if (kick_mode == 2'h2)
      watchdog_kick_in <= swr_pkg::KICK_MID;
    else if (kick_mode == 2'h0 && cnt >= int'(period))
    begin
      cnt = 0;
      watchdog_kick_in <= (watchdog_kick_in == swr_pkg::KICK_HIGH) ?
                          swr_pkg::KICK_LOW : swr_pkg::KICK_HIGH;
    end
    else if (watchdog_kick_in == swr_pkg::KICK_MID)
      watchdog_kick_in <= swr_pkg::KICK_LOW;
  end
endmodule

/* File: bench/supervisor_watchdog_reset_bench.sv */
// self-checking bench for the supervisor watchdog reset block
`timescale 1ns/100ps
module supervisor_watchdog_reset_bench;
  logic        clock, rst_n, main_above_thresh, main_above_backup, power_fail_sense_in;
  logic        timing_source_select, timing_source_in, chip_enable_in_n;
  logic [1:0]  watchdog_kick_in, kick_mode;
  logic        rail_on_main, backup_active_out, low_line_out_n, power_fail_out_n;
  logic        watchdog_fault_out_n, chip_enable_out_n, reset_out_n, reset_out;
  logic [31:0] seed = 32'h884323F7;
  logic [31:0] rv;
  int          err_total = 0;
  int          total_checks = 0;
  int          n;
  // short counts keep the run brief: 16 reset ticks, 8 and 16 watchdog ticks
  swr_top #(.RST_TICKS(24'h000010), .WD_FAST(24'h000008), .WD_SLOW(24'h000010)) u_swr_top (
    .clock(clock), .rst_n(rst_n), .main_above_thresh(main_above_thresh),
    .main_above_backup(main_above_backup), .power_fail_sense_in(power_fail_sense_in),
    .timing_source_select(timing_source_select), .timing_source_in(timing_source_in),
    .watchdog_kick_in(watchdog_kick_in), .chip_enable_in_n(chip_enable_in_n),
    .rail_on_main(rail_on_main), .backup_active_out(backup_active_out),
    .low_line_out_n(low_line_out_n), .power_fail_out_n(power_fail_out_n),
    .watchdog_fault_out_n(watchdog_fault_out_n), .chip_enable_out_n(chip_enable_out_n),
    .reset_out_n(reset_out_n), .reset_out(reset_out));
  swr_host_model u_swr_host_model (.clock(clock), .kick_mode(kick_mode),
    .period(16'h0028), .watchdog_kick_in(watchdog_kick_in));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // ticks to clock cycles at the internal 25-cycle tick
  function automatic int tcyc(input int t);
    return t * 25;
  endfunction
  task automatic chk(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t %s", $time, what);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (reset_out_n !== v && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic pulses(input int k);
    repeat (k)
    begin
      timing_source_in = 1'b1;
      cyc(5);
      timing_source_in = 1'b0;
      cyc(5);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    #400000;
    err_total++;
    results();
  end
  initial
  begin
    rst_n = 0; main_above_thresh = 0; main_above_backup = 0; power_fail_sense_in = 1;
    timing_source_select = 1; timing_source_in = 0; chip_enable_in_n = 0; kick_mode = 2'h2;
    cyc(3);
    chk(reset_out, 1'b1, "reset high");
    chk(watchdog_fault_out_n, 1'b1, "fault in reset");
    rst_n = 1;
    cyc(20);
    chk(reset_out_n, 1'b0, "supply low reset");
    chk(low_line_out_n, 1'b0, "low line");
    chk(chip_enable_out_n, 1'b1, "ce blocked");
    main_above_backup = 1; main_above_thresh = 1;
    cyc(6);
    chk(low_line_out_n, 1'b1, "low line back");
    chk(rail_on_main, 1'b1, "rail main");
    chk(backup_active_out, 1'b0, "backup off");
    wait_rst(1'b1, tcyc(16) + 100);
    chk(logic'(n >= tcyc(15) && n <= tcyc(16) + 30), 1'b1, "power-up hold");
    cyc(600);
    chk(reset_out_n & watchdog_fault_out_n, 1'b1, "mid kick off");
    $display("test power-up done");
    kick_mode = 2'h0;
    repeat (60)
    begin
      rv = xs();
      chip_enable_in_n = rv[0];
      rv = xs();
      power_fail_sense_in = rv[0];
      cyc(8);
      chk(chip_enable_out_n, chip_enable_in_n, "ce pass");
      chk(power_fail_out_n, power_fail_sense_in, "power fail");
      chk(reset_out_n & watchdog_fault_out_n, 1'b1, "kicked no reset");
    end
    $display("test pass-through done");
    chip_enable_in_n = 0; kick_mode = 2'h1;
    wait_rst(1'b0, tcyc(8) + 100);
    chk(logic'(n >= tcyc(7) - 40 && reset_out_n === 1'b0), 1'b1, "wd reset");
    chk(watchdog_fault_out_n, 1'b1, "fault high in reset");
    cyc(250);
    chk(chip_enable_out_n, 1'b0, "ce held low");
    cyc(70);
    chk(chip_enable_out_n, 1'b1, "ce cut");
    wait_rst(1'b1, 200);
    cyc(3);
    chk(watchdog_fault_out_n, 1'b0, "fault low");
    cyc(30);
    chk(watchdog_fault_out_n, 1'b0, "fault stays");
    kick_mode = 2'h0;
    cyc(8);
    chk(watchdog_fault_out_n, 1'b1, "fault cleared");
    $display("test watchdog done");
    timing_source_in = 1; cyc(45); kick_mode = 2'h1;
    wait_rst(1'b0, tcyc(16) + 100);
    chk(logic'(n >= tcyc(15) - 40 && reset_out_n === 1'b0), 1'b1, "slow timeout");
    wait_rst(1'b1, tcyc(16) + 100);
    timing_source_select = 0; timing_source_in = 0;
    cyc(600);
    chk(reset_out_n, 1'b1, "no ext ticks");
    pulses(12);
    chk(reset_out_n, 1'b0, "ext timeout");
    pulses(14);
    chk(reset_out_n, 1'b1, "ext reset hold");
    $display("test timing source done");
    main_above_thresh = 0; main_above_backup = 0;
    cyc(6);
    chk(rail_on_main | reset_out_n | low_line_out_n, 1'b0, "supply lost");
    chk(backup_active_out, 1'b1, "backup on");
    $display("test supply done");
    results();
  end
endmodule
